// ### srk_host.sv
module srk_host
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [5:0] addr_o = 6'h3f,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00,
  output logic notify_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [5:0] a);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    @(negedge clk_i);
    got = rdata_i;
  endtask
  task automatic consume(input logic [15:0] n);
    logic [15:0] p;
    rd(6'h28);
    p[15:8] = got;
    rd(6'h29);
    p[7:0] = got;
    p = p + n;
    wr(6'h28, p[15:8]);
    wr(6'h29, p[7:0]);
    @(negedge clk_i);
    notify_o = 1'b1;
    @(negedge clk_i);
    notify_o = 1'b0;
  endtask
endmodule // srk_host

// ### srk_ka_timer.sv
`include "srk_params.svh"
module srk_ka_timer
  import srk_pkg::*;
#(
  parameter int unsigned TICKS_PER_UNIT = `SRK_TICKS_PER_UNIT
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic run_i,
  input wire logic [7:0] units_i,
  output logic expire_o
);
  logic [27:0] tick;
  logic [7:0] unit_cnt;
  wire tick_end = (tick == 28'(TICKS_PER_UNIT - 1));
  wire unit_end = (unit_cnt == units_i - 8'h01);
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tick <= '0;
      unit_cnt <= '0;
      expire_o <= 1'b0;
    end
    else if (en_i)
    begin
      expire_o <= 1'b0;
      if (!run_i)
      begin
        tick <= '0;
        unit_cnt <= '0;
      end
      else if (tick_end)
      begin
        tick <= '0;
        unit_cnt <= unit_end ? 8'h00 : unit_cnt + 8'h01;
        expire_o <= unit_end;
      end
      else
        tick <= tick + 28'h0000001;
    end
  end
endmodule // srk_ka_timer

// ### srk_params.svh
`ifndef SRK_PARAMS_SVH
`define SRK_PARAMS_SVH
`define SRK_OFF_RSR 6'h26
`define SRK_OFF_RD 6'h28
`define SRK_OFF_WR 6'h2a
`define SRK_OFF_IMR 6'h2c
`define SRK_OFF_FRAG 6'h2d
`define SRK_OFF_KA 6'h2f
`define SRK_RST_PTR 16'h0000
`define SRK_RST_MASK 8'hff
`define SRK_RST_FRAG 16'h4000
`define SRK_RST_KA 8'h00
`define SRK_MASK_USED 8'h1f
`define SRK_CLK_HZ 50000000
`define SRK_KA_UNIT_S 5
`define SRK_TICKS_PER_UNIT (`SRK_CLK_HZ * `SRK_KA_UNIT_S)
`define SRK_KB_SHIFT 10
`define SRK_MODE_TCP 4'h1
`endif

// ### srk_pkg.sv
package srk_pkg;
  typedef enum logic [1:0] {
    SRK_KA_IDLE = 2'b00,
    SRK_KA_ARMED = 2'b01,
    SRK_KA_SEND = 2'b10
  } srk_ka_e;
  typedef logic [15:0] srk_ptr_t;
endpackage

// ### srk_regs.sv
`include "srk_params.svh"
module srk_regs
  import srk_pkg::*;
#(
  parameter int unsigned TICKS_PER_UNIT = `SRK_TICKS_PER_UNIT
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic [5:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic open_cmd_i,
  input wire logic receive_notify_command_notify_i,
  input wire logic manual_ka_i,
  input wire logic rx_byte_i,
  input wire logic tx_byte_i,
  input wire logic [3:0] protocol_mode_i,
  input wire logic state_connected_i,
  input wire logic [4:0] rx_buffer_size_setting_i,
  input wire logic [13:0] rx_base_i,
  input wire logic [4:0] event_i,
  input wire logic flag_clear_i,
  input wire logic [4:0] flag_clear_bits_i,
  input wire logic common_irq_bit_i,
  output logic [4:0] socket_event_flags_o,
  output logic interrupt_out_low_o,
  output logic [15:0] ip_fragment_field_o,
  output logic keepalive_packet_o,
  output logic [13:0] rx_phys_addr_o,
  output logic [15:0] rx_notified_ptr_o
);
  srk_ptr_t rx_read_pointer;
  srk_ptr_t rx_write_pointer;
  srk_ptr_t rx_notified;
  logic [7:0] socket_event_mask;
  logic [15:0] ip_fragment_field;
  logic [7:0] keepalive_interval;
  logic [4:0] flags;
  logic had_data;
  logic next_data_out;
  srk_ka_e ka_state;
  srk_ka_e next_ka_state;
  logic expire;
  logic [7:0] rdata;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode and derived values
  // difference wraps modulo 2^16 just like both pointers
  wire srk_ptr_t rx_received_size =
    rx_write_pointer - rx_read_pointer;
  wire wr_rd_hi = wr_i && hit(addr_i, `SRK_OFF_RD);
  wire wr_rd_lo = wr_i && hit(addr_i, `SRK_OFF_RD + 6'h01);
  wire wr_imr = wr_i && hit(addr_i, `SRK_OFF_IMR);
  wire wr_fr_hi = wr_i && hit(addr_i, `SRK_OFF_FRAG);
  wire wr_fr_lo = wr_i && hit(addr_i, `SRK_OFF_FRAG + 6'h01);
  wire wr_ka = wr_i && hit(addr_i, `SRK_OFF_KA);
  wire tcp_mode = (protocol_mode_i == `SRK_MODE_TCP);
  wire ka_allowed = tcp_mode && state_connected_i && had_data;
  wire auto_run = ka_allowed && (keepalive_interval != 8'h00);
  // a manual request is only honoured while the interval is zero
  wire manual_ok =
    manual_ka_i && (keepalive_interval == 8'h00);
  wire [15:0] buf_bytes =
    16'({11'h000, rx_buffer_size_setting_i} << `SRK_KB_SHIFT);
  wire [15:0] buf_mask = buf_bytes - 16'h0001;
  // sizes are powers of two so modulo is a mask
  wire [15:0] rx_off = rx_read_pointer & buf_mask;
  assign rx_phys_addr_o = rx_base_i + rx_off[13:0];
  assign rx_notified_ptr_o = rx_notified;
  assign socket_event_flags_o = flags;
  assign ip_fragment_field_o = ip_fragment_field;
  wire [4:0] pend = flags & socket_event_mask[4:0];
  assign interrupt_out_low_o = ~((|pend) && common_irq_bit_i);

  always_comb
  begin
    case (addr_i)
      `SRK_OFF_RSR: rdata = rx_received_size[15:8];
      `SRK_OFF_RSR + 6'h01: rdata = rx_received_size[7:0];
      `SRK_OFF_RD: rdata = rx_read_pointer[15:8];
      `SRK_OFF_RD + 6'h01: rdata = rx_read_pointer[7:0];
      `SRK_OFF_WR: rdata = rx_write_pointer[15:8];
      `SRK_OFF_WR + 6'h01: rdata = rx_write_pointer[7:0];
      `SRK_OFF_IMR: rdata = socket_event_mask;
      `SRK_OFF_FRAG: rdata = ip_fragment_field[15:8];
      `SRK_OFF_FRAG + 6'h01: rdata = ip_fragment_field[7:0];
      `SRK_OFF_KA: rdata = keepalive_interval;
      default: rdata = 8'h00;
    endcase
  end

  // one packet per send state; armed only while keepalive is allowed
  always_comb
  begin
    next_ka_state = ka_state;
    next_data_out = 1'b0;
    case (ka_state)
      SRK_KA_IDLE:
        if (ka_allowed)
          next_ka_state = SRK_KA_ARMED;
      SRK_KA_ARMED:
        if (!ka_allowed)
          next_ka_state = SRK_KA_IDLE;
        else if (expire || manual_ok)
          next_ka_state = SRK_KA_SEND;
      SRK_KA_SEND:
      begin
        next_data_out = 1'b1;
        next_ka_state = ka_allowed ? SRK_KA_ARMED : SRK_KA_IDLE;
      end
      default: next_ka_state = SRK_KA_IDLE;
    endcase
  end

  // timer stays cleared unless automatic mode may run
  srk_ka_timer #(.TICKS_PER_UNIT(TICKS_PER_UNIT)) srk_ka_timer_i (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .run_i(auto_run),
    .units_i(keepalive_interval),
    .expire_o(expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pointers
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_read_pointer <= `SRK_RST_PTR;
      rx_write_pointer <= `SRK_RST_PTR;
      rx_notified <= `SRK_RST_PTR;
    end
    else if (en_i)
    begin
      // open wins over a same-cycle pointer write or byte
      if (open_cmd_i)
      begin
        rx_read_pointer <= `SRK_RST_PTR;
        rx_write_pointer <= `SRK_RST_PTR;
        rx_notified <= `SRK_RST_PTR;
      end
      else
      begin
        if (wr_rd_hi)
          rx_read_pointer[15:8] <= wdata_i;
        if (wr_rd_lo)
          rx_read_pointer[7:0] <= wdata_i;
        // wraps naturally at 16 bits; refuse to exceed buffer size
        if (rx_byte_i && (rx_received_size < buf_bytes))
          rx_write_pointer <= rx_write_pointer + 16'h0001;
        if (receive_notify_command_notify_i)
          rx_notified <= rx_read_pointer;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, flags, keepalive
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      socket_event_mask <= `SRK_RST_MASK;
      ip_fragment_field <= `SRK_RST_FRAG;
      keepalive_interval <= `SRK_RST_KA;
      flags <= '0;
      had_data <= 1'b0;
      ka_state <= SRK_KA_IDLE;
      keepalive_packet_o <= 1'b0;
      rdata_o <= 8'h00;
    end
    else if (en_i)
    begin
      if (wr_imr)
        socket_event_mask <= wdata_i & `SRK_MASK_USED;
      if (wr_fr_hi)
        ip_fragment_field[15:8] <= wdata_i;
      if (wr_fr_lo)
        ip_fragment_field[7:0] <= wdata_i;
      if (wr_ka)
        keepalive_interval <= wdata_i;
      // set wins over clear
      flags <= (flags & ~({5{flag_clear_i}} & flag_clear_bits_i))
               | (event_i & socket_event_mask[4:0]);
      if (open_cmd_i || !state_connected_i)
        had_data <= 1'b0;
      else if (rx_byte_i || tx_byte_i)
        had_data <= 1'b1;
      ka_state <= next_ka_state;
      keepalive_packet_o <= next_data_out;
      // read data is captured only on a read strobe and then stands
      if (rd_i)
        rdata_o <= rdata;
    end
  end
endmodule // srk_regs

// ### srk_regs_monitor.sv
module srk_regs_monitor
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic wr_i,
  input wire logic open_cmd_i,
  input wire logic flag_clear_i,
  input wire logic common_irq_bit_i,
  input wire logic [3:0] protocol_mode_i,
  input wire logic [4:0] event_i,
  input wire logic [13:0] rx_base_i,
  input wire logic [4:0] socket_event_flags_o,
  input wire logic interrupt_out_low_o,
  input wire logic [15:0] ip_fragment_field_o,
  input wire logic keepalive_packet_o,
  input wire logic [13:0] rx_phys_addr_o,
  input wire logic [15:0] rx_notified_ptr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_flag_cause: assert property (
    |(socket_event_flags_o & ~$past(socket_event_flags_o))
    |-> $past(event_i) != 5'h00) else $error("flag set without event");
  a_flag_hold: assert property (
    event_i == 5'h00 && !flag_clear_i |=> $stable(socket_event_flags_o))
    else $error("flags changed while idle");
  a_frag_hold: assert property (
    !(en_i && wr_i) |=> $stable(ip_fragment_field_o))
    else $error("fragment field changed without write");
  a_open_ptr: assert property (
    en_i && open_cmd_i |=> rx_notified_ptr_o == 16'h0000)
    else $error("open left notified pointer");
  a_open_phys: assert property (
    en_i && open_cmd_i |=> rx_phys_addr_o == rx_base_i)
    else $error("open left buffer address off base");
  a_int_cause: assert property (
    !interrupt_out_low_o |-> common_irq_bit_i && |socket_event_flags_o)
    else $error("interrupt low without cause");
  a_int_off: assert property (
    !common_irq_bit_i |-> interrupt_out_low_o)
    else $error("interrupt low while common bit clear");
  a_ka_single: assert property (
    keepalive_packet_o |=> !keepalive_packet_o)
    else $error("keepalive pulse too long");
  a_ka_tcp: assert property (
    keepalive_packet_o |-> protocol_mode_i == 4'h1)
    else $error("keepalive outside tcp");
  cover property (keepalive_packet_o);
  cover property (!interrupt_out_low_o);
  cover property (en_i && open_cmd_i);
endmodule // srk_regs_monitor
bind srk_regs srk_regs_monitor srk_regs_monitor_i (.*);

// ### srk_regs_tb_top.sv
module srk_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, nrst_i = 1'b0, opn = 1'b0, man = 1'b0, rxb = 1'b0;
  logic conn = 1'b0, fclr = 1'b0, cirq = 1'b0, wr, rd, ntf, interrupt_out_low, ka;
  logic en = 1'b1, txb = 1'b0;
  logic [3:0] mode = 4'h1;
  logic [4:0] ev = 5'h00, fb = 5'h00, bsz = 5'h01, flags;
  logic [5:0] addr;
  logic [7:0] rdata, wdata;
  logic [13:0] phys;
  logic [15:0] frag, nptr;
  int err_count = 0, checked = 0, ka_cnt = 0, cyc = 0;
  always #10 clk_i = ~clk_i;
  srk_regs #(.TICKS_PER_UNIT(4)) srk_regs_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .en_i(en), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
    .rdata_o(rdata), .open_cmd_i(opn), .receive_notify_command_notify_i(ntf),
    .manual_ka_i(man), .rx_byte_i(rxb), .tx_byte_i(txb),
    .protocol_mode_i(mode), .state_connected_i(conn),
    .rx_buffer_size_setting_i(bsz), .rx_base_i(14'h0400), .event_i(ev),
    .flag_clear_i(fclr), .flag_clear_bits_i(fb), .common_irq_bit_i(cirq),
    .socket_event_flags_o(flags), .interrupt_out_low_o(interrupt_out_low),
    .ip_fragment_field_o(frag), .keepalive_packet_o(ka),
    .rx_phys_addr_o(phys), .rx_notified_ptr_o(nptr));
  srk_host srk_host_i (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .notify_o(ntf));
  always @(posedge clk_i)
  begin
    cyc++;
    if (ka)
      ka_cnt++;
    if (cyc == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
      $display("Error %0t: got %h expected %h", $time, g, e);
    if (g !== e)
      err_count++;
  endtask
  task automatic rd16(input logic [5:0] a, input logic [15:0] e);
    logic [7:0] h;
    srk_host_i.rd(a);
    h = srk_host_i.got;
    srk_host_i.rd(a + 6'h01);
    chk({h, srk_host_i.got}, e);
  endtask
  task automatic rd8(input logic [5:0] a, input logic [7:0] e);
    srk_host_i.rd(a);
    chk({8'h00, srk_host_i.got}, {8'h00, e});
  endtask
  task automatic hold(ref logic s, input int n);
    @(negedge clk_i);
    s = 1'b1;
    repeat (n) @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic ka_win(input int e);
    repeat (8) @(negedge clk_i);
    ka_cnt = 0;
    repeat (32) @(negedge clk_i);
    chk(16'(ka_cnt), 16'(e));
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    rd16(6'h28, 16'h0000);
    rd16(6'h2a, 16'h0000);
    rd16(6'h2d, 16'h4000);
    rd8(6'h2f, 8'h00);
    rd8(6'h2c, 8'hff);
    rd8(6'h30, 8'h00);
    srk_host_i.wr(6'h26, 8'hff);
    rd16(6'h26, 16'h0000);
    srk_host_i.wr(6'h2c, 8'he4);
    rd8(6'h2c, 8'h04);
    ev = 5'h1f;
    @(negedge clk_i);
    ev = 5'h00;
    chk({11'h000, flags}, 16'h0004);
    cirq = 1'b1;
    #1 chk({15'h0000, interrupt_out_low}, 16'h0000);
    fb = 5'h1f;
    hold(fclr, 1);
    #1 chk({15'h0000, interrupt_out_low}, 16'h0001);
    hold(rxb, 5);
    rd16(6'h2a, 16'h0005);
    srk_host_i.consume(16'h0003);
    chk(nptr, 16'h0003);
    rd16(6'h26, 16'h0002);
    chk({2'b00, phys}, 16'h0403);
    hold(rxb, 1100);
    rd16(6'h26, 16'h0400);
    srk_host_i.consume(16'h0400);
    rd16(6'h28, 16'h0403);
    chk({2'b00, phys}, 16'h0403);
    bsz = 5'h02;
    #1 chk({2'b00, phys}, 16'h0803);
    hold(opn, 1);
    rd16(6'h28, 16'h0000);
    rd16(6'h2a, 16'h0000);
    // bytes offered while the clock enable is low must be lost
    en = 1'b0;
    hold(rxb, 3);
    en = 1'b1;
    rd16(6'h2a, 16'h0000);
    // read pointer wraps through 0xffff with the carry dropped
    srk_host_i.consume(16'hffff);
    rd16(6'h26, 16'h0001);
    srk_host_i.consume(16'h0001);
    rd16(6'h28, 16'h0000);
    srk_host_i.wr(6'h2d, 8'h00);
    #1 chk(frag, 16'h0000);
    conn = 1'b1;
    hold(txb, 1);
    ka_cnt = 0;
    hold(man, 1);
    repeat (6) @(negedge clk_i);
    chk(16'(ka_cnt), 16'h0001);
    srk_host_i.wr(6'h2f, 8'h02);
    man = 1'b1;
    ka_win(4);
    man = 1'b0;
    srk_host_i.wr(6'h2f, 8'h00);
    repeat (8) @(negedge clk_i);
    mode = 4'h2;
    srk_host_i.wr(6'h2f, 8'h02);
    ka_win(0);
    conn = 1'b0;
    @(negedge clk_i);
    mode = 4'h1;
    ka_win(0);
    wrap_up();
  end
endmodule // srk_regs_tb_top
